// *** verilog/adcc_pkg.sv ***
// Package for the converter control block: offsets, fields, constants
package adcc_pkg;
   // Register byte offsets on APB
   localparam logic [7:0] ADCC_CTRL_OFF = 8'h00;
   localparam logic [7:0] ADCC_RESULT_OFF = 8'h04;
   localparam logic [7:0] ADCC_IRQ_STAT_OFF = 8'h08;
   localparam logic [7:0] ADCC_IRQ_CLR_OFF = 8'h0C;
   localparam logic [7:0] ADCC_IRQ_EN_OFF = 8'h10;
   localparam logic [7:0] ADCC_CLKDIV_OFF = 8'h14;
   // Control field positions
   localparam int ADCC_JUSTIFY_BIT = 7;
   localparam int ADCC_REFSEL_BIT = 6;
   localparam int ADCC_UNUSED_BIT = 5;
   localparam int ADCC_CHAN_LSB = 2;
   localparam int ADCC_GO_BIT = 1;
   localparam int ADCC_POWER_BIT = 0;
   // Values after reset
   localparam logic [7:0] ADCC_CTRL_RST = 8'h00;
   localparam logic [7:0] ADCC_CLKDIV_RST = 8'h03;
   // Writable control bits (bit 5 and go handled apart)
   localparam logic [7:0] ADCC_CTRL_WMASK = 8'hDD;
   // Timing in conversion clock periods
   localparam logic [3:0] ADCC_CONV_PERIODS = 4'hB;
   localparam logic [3:0] ADCC_ABORT_PERIODS = 4'h2;

   typedef enum logic [1:0]
   {
      ADCC_IDLE = 2'b00,
      ADCC_CONV = 2'b01,
      ADCC_HOLD = 2'b10
   } adcc_state_e;

   // Signals toward the analog core
   typedef struct packed
   {
      logic power_on;
      logic ref_external;
      logic [2:0] channel;
      logic sample;
   } adcc_analog_s;
endpackage

// *** verilog/adcc_top.sv ***
// Converter control register with APB slave, sequencer and interrupt
`timescale 1ns/10ps
module adcc_top
   import adcc_pkg::*;
#(
   parameter int RES_W = 10
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog core
   output adcc_analog_s analog,
   input wire logic [RES_W-1:0] core_result,
   // Interrupt
   output logic irq
);
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] div_q, div_d;
   logic [7:0] tick_cnt_q, tick_cnt_d;
   logic [3:0] per_q, per_d;
   logic [RES_W-1:0] res_q, res_d;
   logic stat_q, stat_d;
   logic en_q, en_d;
   adcc_state_e st_q, st_d;
   logic [31:0] rdata_d;
   logic wr, rd, tick, hw_done, go_w1, go_w0, done_ok;
   logic [15:0] res_just;

   assign wr = psel & penable & pwrite;
   assign rd = psel & ~pwrite;
   assign pready = 1'b1;
   assign tick = (tick_cnt_q == div_q);
   assign go_w1 = wr && paddr == ADCC_CTRL_OFF && pwdata[ADCC_GO_BIT];
   assign go_w0 = wr && paddr == ADCC_CTRL_OFF && !pwdata[ADCC_GO_BIT];
   assign hw_done = (st_q == ADCC_CONV) && tick
      && (per_q == ADCC_CONV_PERIODS - 4'h1);
   // End counts only when no abort lands in the same cycle
   assign done_ok = hw_done && !go_w0 && ctrl_d[ADCC_POWER_BIT];

   // Result placement chosen by bit 7 only
   always_comb
   begin
      res_just = '0;
      if (ctrl_q[ADCC_JUSTIFY_BIT])
      begin
         res_just[RES_W-1:0] = res_q;
      end
      else
      begin
         res_just[15:16-RES_W] = res_q;
      end
   end

   // Sequencer, control register and conversion clock
   always_comb
   begin
      ctrl_d = ctrl_q;
      div_d = div_q;
      st_d = st_q;
      per_d = per_q;
      res_d = res_q;
      tick_cnt_d = tick ? 8'h00 : tick_cnt_q + 8'h01;
      if (wr && paddr == ADCC_CTRL_OFF)
      begin
         // Bit 5 never stored, bit 1 handled by sequencer
         ctrl_d = (ctrl_q & ~ADCC_CTRL_WMASK)
            | (pwdata[7:0] & ADCC_CTRL_WMASK);
      end
      if (wr && paddr == ADCC_CLKDIV_OFF)
      begin
         div_d = pwdata[7:0];
      end
      unique case (st_q)
         ADCC_IDLE:
         begin
            if (go_w1 && ctrl_d[ADCC_POWER_BIT])
            begin
               st_d = ADCC_CONV;
               per_d = 4'h0;
               tick_cnt_d = 8'h00;
               ctrl_d[ADCC_GO_BIT] = 1'b1;
            end
         end
         ADCC_CONV:
         begin
            if (go_w0 || !ctrl_d[ADCC_POWER_BIT])
            begin
               // Abort: result untouched, wait before resuming
               st_d = ADCC_HOLD;
               per_d = 4'h0;
               ctrl_d[ADCC_GO_BIT] = 1'b0;
            end
            else if (hw_done)
            begin
               st_d = ADCC_IDLE;
               res_d = core_result;
               ctrl_d[ADCC_GO_BIT] = 1'b0;
            end
            else if (tick)
            begin
               per_d = per_q + 4'h1;
            end
         end
         ADCC_HOLD:
         begin
            if (tick && per_q == ADCC_ABORT_PERIODS - 4'h1)
            begin
               st_d = ADCC_IDLE;
            end
            else if (tick)
            begin
               per_d = per_q + 4'h1;
            end
         end
         default:
         begin
            st_d = ADCC_IDLE;
         end
      endcase
   end

   // Sticky complete flag, set wins over clear
   always_comb
   begin
      en_d = en_q;
      stat_d = stat_q;
      if (wr && paddr == ADCC_IRQ_EN_OFF)
      begin
         en_d = pwdata[0];
      end
      if (wr && paddr == ADCC_IRQ_CLR_OFF && pwdata[0])
      begin
         stat_d = 1'b0;
      end
      if (done_ok)
      begin
         stat_d = 1'b1;
      end
   end

   // Read mux
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (rd)
      begin
         unique case (paddr)
            ADCC_CTRL_OFF: rdata_d[7:0] = ctrl_q;
            ADCC_RESULT_OFF: rdata_d[15:0] = res_just;
            ADCC_IRQ_STAT_OFF: rdata_d[0] = stat_q;
            ADCC_IRQ_EN_OFF: rdata_d[0] = en_q;
            ADCC_CLKDIV_OFF: rdata_d[7:0] = div_q;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= ADCC_CTRL_RST;
         div_q <= ADCC_CLKDIV_RST;
         tick_cnt_q <= 8'h00;
         per_q <= 4'h0;
         res_q <= '0;
         st_q <= ADCC_IDLE;
         stat_q <= 1'b0;
         en_q <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         div_q <= div_d;
         tick_cnt_q <= tick_cnt_d;
         per_q <= per_d;
         res_q <= res_d;
         st_q <= st_d;
         stat_q <= stat_d;
         en_q <= en_d;
         if (psel && !penable)
         begin
            prdata <= rdata_d;
         end
      end
   end

   assign pslverr = 1'b0;
   assign irq = stat_q & en_q;
   // Signals toward the analog core
   always_comb
   begin
      analog.power_on = ctrl_q[ADCC_POWER_BIT];
      analog.ref_external = ctrl_q[ADCC_REFSEL_BIT];
      analog.channel = ctrl_q[ADCC_CHAN_LSB+2:ADCC_CHAN_LSB];
      // Sampling while idle and powered, also after abort wait
      analog.sample = ctrl_q[ADCC_POWER_BIT] && st_q == ADCC_IDLE;
   end

   // Checks
   sequence conv_start_s;
      st_q == ADCC_IDLE && go_w1 && ctrl_d[ADCC_POWER_BIT];
   endsequence
   sequence go_high_s;
      ctrl_q[ADCC_GO_BIT] && st_q == ADCC_CONV;
   endsequence

   go_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv_start_s |=> go_high_s)
      else $error("go bit not set after start");
   go_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
      done_ok
      |=> !ctrl_q[ADCC_GO_BIT] && st_q == ADCC_IDLE)
      else $error("go bit not cleared at end");
   go_state_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_q[ADCC_GO_BIT] == (st_q == ADCC_CONV))
      else $error("go bit disagrees with state");
   flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      done_ok |=> stat_q)
      else $error("complete flag not set");
   irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
      irq == (stat_q && en_q))
      else $error("interrupt level wrong");
   abort_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == ADCC_CONV && go_w0 |=> st_q == ADCC_HOLD && $stable(res_q))
      else $error("abort changed result");
   power_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_q[ADCC_POWER_BIT] |-> !analog.power_on && !analog.sample)
      else $error("converter active while off");
   bit5_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_q[ADCC_UNUSED_BIT])
      else $error("unused bit set");
   justify_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_q[ADCC_JUSTIFY_BIT] |-> res_just[RES_W-1:0] == res_q)
      else $error("right justification wrong");
   ref_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      analog.ref_external == ctrl_q[ADCC_REFSEL_BIT])
      else $error("reference select wrong");
   chan_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == ADCC_CTRL_OFF |=> analog.channel == $past(pwdata[4:2]))
      else $error("channel select wrong");
endmodule

// *** sim/adcc_core_model.sv ***
// Behavioural analog core answering the control block
`timescale 1ns/10ps
module adcc_core_model
   import adcc_pkg::*;
(
   // Clock
   input wire logic pclk,
   // Control side
   input wire adcc_analog_s analog,
   output logic [9:0] core_result
);
   logic [9:0] junk_q = 10'h155;

   // Unpowered core gives a changing pattern
   always_ff @(posedge pclk)
      junk_q <= ~junk_q;

   always_comb
      if (analog.power_on)
         core_result = {analog.ref_external, 3'h5, analog.channel, 3'h3};
      else
         core_result = junk_q;
endmodule

// *** sim/tb.sv ***
// Testbench for the converter control block
`timescale 1ns/10ps
module tb
   import adcc_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [9:0] core_result;
   logic [31:0] rv;
   logic [9:0] last;
   adcc_analog_s analog;
   int err_count = 0;
   int comparisons = 0;

   adcc_top u_adcc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog(analog),
      .core_result(core_result), .irq(irq));
   adcc_core_model u_adcc_core_model (.pclk(pclk), .analog(analog),
      .core_result(core_result));

   initial
   begin
      forever #5 pclk = ~pclk;
   end

   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the access edge settle before outputs are compared
      @(negedge pclk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic conv(input logic [7:0] c);
      int n;
      n = 0;
      apb(1'b1, ADCC_CTRL_OFF, {24'h0, c});
      chk({31'h0, analog.sample}, 32'h0);
      apb(1'b0, ADCC_CTRL_OFF, 32'h0);
      chk(rv, {24'h0, c});
      do
      begin
         apb(1'b0, ADCC_CTRL_OFF, 32'h0);
         n++;
      end
      while (rv[1] !== 1'b0 && n < 60);
      chk(rv, {24'h0, c & 8'hFD});
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      #100000;
      err_count++;
      end_sim();
   end

   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADCC_CTRL_OFF, 32'h0);
      chk(rv, 32'h0);
      apb(1'b0, ADCC_CLKDIV_OFF, 32'h0);
      chk(rv, {24'h0, ADCC_CLKDIV_RST});
      apb(1'b1, ADCC_CTRL_OFF, 32'hE5);
      apb(1'b0, ADCC_CTRL_OFF, 32'h0);
      chk(rv, 32'hC5);
      chk({26'h0, analog}, 32'h33);
      $display("test registers done");
      apb(1'b1, ADCC_IRQ_EN_OFF, 32'h1);
      for (int j = 0; j < 2; j++)
      begin
         conv({j[0], 2'b00, (j ? 3'h6 : 3'h3), 2'b11});
         last = {1'b0, 3'h5, (j ? 3'h6 : 3'h3), 3'h3};
         apb(1'b0, ADCC_RESULT_OFF, 32'h0);
         chk(rv, j ? {22'h0, last} : {16'h0, last, 6'h0});
         apb(1'b0, ADCC_IRQ_STAT_OFF, 32'h0);
         chk(rv, 32'h1);
         chk({31'h0, irq}, 32'h1);
         apb(1'b1, ADCC_IRQ_CLR_OFF, 32'h1);
         chk({31'h0, irq}, 32'h0);
      end
      $display("test conversion done");
      apb(1'b1, ADCC_CTRL_OFF, 32'h8B);
      apb(1'b1, ADCC_CTRL_OFF, 32'h89);
      repeat (20) @(posedge pclk);
      chk({31'h0, analog.sample}, 32'h1);
      apb(1'b0, ADCC_RESULT_OFF, 32'h0);
      chk(rv, {22'h0, last});
      apb(1'b0, ADCC_IRQ_STAT_OFF, 32'h0);
      chk(rv, 32'h0);
      $display("test abort done");
      apb(1'b1, ADCC_CTRL_OFF, 32'h02);
      apb(1'b0, ADCC_CTRL_OFF, 32'h0);
      chk(rv, 32'h0);
      chk({31'h0, analog.power_on}, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk(rv, 32'h0);
      chk({31'h0, pslverr}, 32'h0);
      $display("test power done");
      end_sim();
   end
endmodule
